// ===== clk_ctrl_consts.svh
// Register offsets, field positions and reset values of the clock control unit
// Assumes 32-bit APB with a 12-bit byte address
`ifndef CLK_CTRL_CONSTS_SVH
`define CLK_CTRL_CONSTS_SVH
`define OFS_CTRL     12'h000
`define OFS_CFG      12'h004
`define OFS_CTRLSTS  12'h008
`define OFS_LDCTRL   12'h00c
`define OFS_CLKINT   12'h010
// Oscillator index shared by enable, ready, flag and stable vectors
`define OSC_LSI      0
`define OSC_LSE      1
`define OSC_HSI      2
`define OSC_HSE      3
`define OSC_PLL      4
`define OSC_MSI      5
// Extra synchronised inputs
`define SY_FAIL      6
`define SY_VDD       7
`define SY_WAKE      8
`define EN_RST       6'h20
`define TRIM_RST     5'h10
`define RANGE_4MHZ   4'h6
`define RANGE_MAX    4'h6
`define SYSTICK_LAST 3'h7
`define LD_SOFT_BIT  16
`define INT_EN_LSB   8
`define INT_CLR_LSB  16
`endif

// ===== clk_ctrl_pkg.sv
// Types of the clock control unit
// Assumes the constants header is compiled alongside
package clk_ctrl_pkg;
    typedef enum logic [1:0] {SRC_MSI, SRC_HSI, SRC_HSE, SRC_PLL} system_clock_src_e;
endpackage

// ===== clock_source_control_unit.sv
// Clock source, PLL setup, bus clock enables and low-power-domain reset control
// Assumes APB master on pclk; oscillator status and events arrive asynchronously
// Function
// (RULE1) Soft bit or supply event resets low-power domain
// (RULE2) Seven multispeed ranges, 4-bit field, default 4 MHz
// (RULE3) Reset or standby wake selects multispeed at 4 MHz
// (RULE4) Software keeps bus clocks within their limits
// (RULE5) System tick reference is AHB divided by 8
// (RULE6) Timer clock doubles unless APB prescaler is 1
// (RULE7) Fast bypass needs bypass and enable bits
// (RULE8) Fast external released on ready, interrupt on ready
// (RULE9) Fast internal gated by enable, released on ready
// (RULE10) Fast internal PLL input divided by 1 or 2
// (RULE11) Factory calibration loaded after every reset
// (RULE12) Five-bit software trim for fast internal
// (RULE13) Multispeed gated by enable, used after ready
// (RULE14) Fast external failure falls back to multispeed
// (RULE15) PLL settings locked while PLL enabled
// (RULE16) PLL input predivide then final divide by 1 or 2
// (RULE17) PLL ready raises enabled interrupt
// (RULE18) Software keeps PLL system clock 32 to 108 MHz
// (RULE19) Software waits slow external stop and restart
// (RULE20) Slow external released on ready, interrupt on ready
// (RULE21) Slow bypass needs bypass and enable bits
// (RULE22) Slow internal gated by enable, released on ready
// (RULE23) Clock switch completes only when target ready; wake or failure forces multispeed without waiting for ready
// (RULE24) Ready reads zero while oscillator disabled; ready clears one cycle after the enable does
`timescale 1ns/10ps
`default_nettype none
`include "clk_ctrl_consts.svh"
module clock_source_control_unit
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [5:0]  osc_stable,
    input  wire logic        fast_external_fail,
    input  wire logic        vdd_power_event,
    input  wire logic        standby_wake,
    input  wire logic [8:0]  factory_calibration,
    output logic      [5:0]  osc_enable,
    output logic      [5:0]  osc_release,
    output logic             fast_external_bypass,
    output logic             slow_external_bypass,
    output logic      [3:0]  multispeed_range_select,
    output logic      [4:0]  fast_internal_trim,
    output logic      [8:0]  fast_internal_calibration,
    output logic             pll_source_external,
    output logic             pll_internal_input_divide,
    output logic             pll_external_input_divide,
    output logic             pll_final_divide,
    output logic      [4:0]  pll_multiply_factor,
    output logic      [1:0]  system_clock_select,
    output logic             lowpower_domain_reset,
    output logic             clock_irq,
    output logic             ahb_tick,
    output logic             apb1_tick,
    output logic             apb2_tick,
    output logic             timer1_tick,
    output logic             timer2_tick,
    output logic             systick_tick
);

    function automatic logic [2:0] src_idx(input logic [1:0] s);
        case (s)
            2'h1:    src_idx = 3'(`OSC_HSI);
            2'h2:    src_idx = 3'(`OSC_HSE);
            2'h3:    src_idx = 3'(`OSC_PLL);
            default: src_idx = 3'(`OSC_MSI);
        endcase
    endfunction

    function automatic logic [4:0] apb_div(input logic [2:0] p);
        apb_div = p[2] ? (5'h02 << p[1:0]) : 5'h01;
    endfunction

    // Timer pulse twice per APB period: every half period of the APB divider
    function automatic logic timer_hit(input logic [3:0] cnt, input logic [4:0] d);
        timer_hit = (cnt & (d[4:1] - 4'h1)) == (d[4:1] - 4'h1);
    endfunction

    logic [8:0]  sy1_q;
    logic [8:0]  sy2_q;
    logic [5:0]  en_q;
    logic [5:0]  rdy_q;
    logic [5:0]  flag_q;
    logic [5:0]  ien_q;
    logic [5:0]  rise;
    logic        hse_bp_q;
    logic        lse_bp_q;
    logic        ld_soft_q;
    logic [3:0]  range_q;
    logic [4:0]  trim_q;
    logic [8:0]  cal_q;
    logic        cal_done_q;
    logic        pll_src_q;
    logic        pll_hsi_div_q;
    logic        pll_hse_div_q;
    logic        pll_fin_div_q;
    logic [4:0]  mul_q;
    logic [3:0]  ahb_pre_q;
    logic [2:0]  apb1_pre_q;
    logic [2:0]  apb2_pre_q;
    logic [1:0]  sw_q;
    clk_ctrl_pkg::system_clock_src_e sws_q;
    logic [8:0]  ahb_cnt_q;
    logic [3:0]  apb1_cnt_q;
    logic [3:0]  apb2_cnt_q;
    logic [2:0]  st_cnt_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_d;
    logic [9:0]  ahb_div;
    logic [4:0]  d1;
    logic [4:0]  d2;
    logic        hit;
    logic        wr;
    logic        fail;
    logic        wake;
    logic        on_hse;

    // Two-flop synchronisers for asynchronous status and event inputs
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            sy1_q <= 9'h000;
            sy2_q <= 9'h000;
        end
        else
        begin
            sy1_q <= {standby_wake, vdd_power_event, fast_external_fail, osc_stable};
            sy2_q <= sy1_q;
        end

    assign fail   = sy2_q[`SY_FAIL];
    assign wake   = sy2_q[`SY_WAKE];
    assign wr     = psel && penable && pwrite;
    assign on_hse = (sws_q == clk_ctrl_pkg::SRC_HSE) ||
                    ((sws_q == clk_ctrl_pkg::SRC_PLL) && pll_src_q);
    assign hit    = (paddr == `OFS_CTRL) || (paddr == `OFS_CFG) || (paddr == `OFS_CTRLSTS) ||
                    (paddr == `OFS_LDCTRL) || (paddr == `OFS_CLKINT);

    // Oscillator enables
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            en_q <= `EN_RST;
        else
        begin
            if (wr && paddr == `OFS_CTRL)
            begin
                en_q[`OSC_HSI] <= pwdata[0];
                en_q[`OSC_HSE] <= pwdata[16];
                en_q[`OSC_PLL] <= pwdata[24];
            end
            if (wr && paddr == `OFS_CTRLSTS)
            begin
                en_q[`OSC_LSI] <= pwdata[0];
                en_q[`OSC_MSI] <= pwdata[2];
            end
            if (wr && paddr == `OFS_LDCTRL)
                en_q[`OSC_LSE] <= pwdata[0];
            if (lowpower_domain_reset)
                en_q[`OSC_LSE] <= 1'b0;
            if (sws_q == clk_ctrl_pkg::SRC_MSI || wake)
                en_q[`OSC_MSI] <= 1'b1;  // RULE3
            if (fail && on_hse)
            begin
                en_q[`OSC_HSE] <= 1'b0;  // RULE14
                en_q[`OSC_MSI] <= 1'b1;
                if (pll_src_q)
                    en_q[`OSC_PLL] <= 1'b0;
            end
        end

    // Ready follows enable and stable status, cleared one cycle after disable
    assign rise = en_q & sy2_q[5:0] & ~rdy_q;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            rdy_q <= 6'h00;
        else
            rdy_q <= en_q & sy2_q[5:0];  // RULE24

    assign osc_release = en_q & rdy_q;  // RULE8 RULE9 RULE13 RULE20 RULE22
    assign osc_enable  = en_q;

    // Ready interrupt flags; a new ready event wins over a clear
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            flag_q <= 6'h00;
            ien_q  <= 6'h00;
        end
        else
        begin
            if (wr && paddr == `OFS_CLKINT)
            begin
                ien_q  <= pwdata[`INT_EN_LSB+5:`INT_EN_LSB];
                flag_q <= (flag_q & ~pwdata[`INT_CLR_LSB+5:`INT_CLR_LSB]) | rise;
            end
            else
                flag_q <= flag_q | rise;
        end

    assign clock_irq = |(flag_q & ien_q);  // RULE8 RULE17 RULE20

    // Bypass selections and low-power-domain control
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            hse_bp_q  <= 1'b0;
            lse_bp_q  <= 1'b0;
            ld_soft_q <= 1'b0;
        end
        else
        begin
            if (wr && paddr == `OFS_CTRL && !en_q[`OSC_HSE])
                hse_bp_q <= pwdata[18];
            if (wr && paddr == `OFS_LDCTRL)
            begin
                if (!en_q[`OSC_LSE])
                    lse_bp_q <= pwdata[2];
                ld_soft_q <= pwdata[`LD_SOFT_BIT];
            end
            if (lowpower_domain_reset)
                lse_bp_q <= 1'b0;
        end

    assign fast_external_bypass  = hse_bp_q && en_q[`OSC_HSE];  // RULE7
    assign slow_external_bypass  = lse_bp_q && en_q[`OSC_LSE];  // RULE21
    assign lowpower_domain_reset = ld_soft_q || sy2_q[`SY_VDD];  // RULE1

    // Multispeed range and fast internal trim
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            range_q <= `RANGE_4MHZ;
            trim_q  <= `TRIM_RST;
        end
        else
        begin
            if (wr && paddr == `OFS_CTRLSTS && pwdata[7:4] <= `RANGE_MAX)
                range_q <= pwdata[7:4];  // RULE2
            if (wr && paddr == `OFS_CTRL)
                trim_q <= pwdata[6:2];  // RULE12
            if (wake)
                range_q <= `RANGE_4MHZ;  // RULE3
        end

    assign multispeed_range_select = range_q;
    assign fast_internal_trim      = trim_q;

    // Calibration sampled once after each reset release
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            cal_q      <= 9'h000;
            cal_done_q <= 1'b0;
        end
        else if (!cal_done_q)
        begin
            cal_q      <= factory_calibration;  // RULE11
            cal_done_q <= 1'b1;
        end

    assign fast_internal_calibration = cal_q;

    // PLL setup, writable only while the PLL is off
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            pll_src_q     <= 1'b0;
            pll_hsi_div_q <= 1'b0;
            pll_hse_div_q <= 1'b0;
            pll_fin_div_q <= 1'b0;
            mul_q         <= 5'h00;
        end
        else if (wr && paddr == `OFS_CFG && !en_q[`OSC_PLL])  // RULE15
        begin
            pll_src_q     <= pwdata[16];
            pll_hse_div_q <= pwdata[17];  // RULE16
            pll_hsi_div_q <= pwdata[18];  // RULE10
            pll_fin_div_q <= pwdata[19];
            mul_q         <= pwdata[24:20];
        end

    assign pll_source_external       = pll_src_q;
    assign pll_internal_input_divide = pll_hsi_div_q;
    assign pll_external_input_divide = pll_hse_div_q;
    assign pll_final_divide          = pll_fin_div_q;
    assign pll_multiply_factor       = mul_q;

    // Prescalers and system clock request
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            ahb_pre_q  <= 4'h0;
            apb1_pre_q <= 3'h0;
            apb2_pre_q <= 3'h0;
            sw_q       <= 2'h0;
        end
        else
        begin
            if (wr && paddr == `OFS_CFG)
            begin
                sw_q       <= pwdata[1:0];
                ahb_pre_q  <= pwdata[7:4];
                apb1_pre_q <= pwdata[10:8];
                apb2_pre_q <= pwdata[13:11];
            end
            if (wake || (fail && on_hse))
                sw_q <= 2'h0;
        end

    // Switch completes only on a ready target; wake or failure forces multispeed without waiting
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            sws_q <= clk_ctrl_pkg::SRC_MSI;
        else if (wake || (fail && on_hse))
            sws_q <= clk_ctrl_pkg::SRC_MSI;  // RULE3 RULE14
        else if (rdy_q[src_idx(sw_q)])
            sws_q <= clk_ctrl_pkg::system_clock_src_e'(sw_q);  // RULE23

    assign system_clock_select = sws_q;

    // Bus clock enables divided from pclk
    assign ahb_div = ahb_pre_q[3] ? (10'h002 << ahb_pre_q[2:0]) : 10'h001;
    assign d1      = apb_div(apb1_pre_q);
    assign d2      = apb_div(apb2_pre_q);
    assign ahb_tick  = (ahb_cnt_q == 9'(ahb_div - 10'h001));
    assign apb1_tick = ahb_tick && (apb1_cnt_q == 4'(d1 - 5'h01));
    assign apb2_tick = ahb_tick && (apb2_cnt_q == 4'(d2 - 5'h01));
    assign timer1_tick = (d1 == 5'h01) ? apb1_tick :
                         ahb_tick && timer_hit(apb1_cnt_q, d1);  // RULE6
    assign timer2_tick = (d2 == 5'h01) ? apb2_tick :
                         ahb_tick && timer_hit(apb2_cnt_q, d2);  // RULE6
    assign systick_tick = ahb_tick && (st_cnt_q == `SYSTICK_LAST);  // RULE5

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            ahb_cnt_q  <= 9'h000;
            apb1_cnt_q <= 4'h0;
            apb2_cnt_q <= 4'h0;
            st_cnt_q   <= 3'h0;
        end
        else
        begin
            ahb_cnt_q <= ahb_tick ? 9'h000 : ahb_cnt_q + 9'h001;
            if (ahb_tick)
            begin
                apb1_cnt_q <= apb1_tick ? 4'h0 : apb1_cnt_q + 4'h1;
                apb2_cnt_q <= apb2_tick ? 4'h0 : apb2_cnt_q + 4'h1;
                st_cnt_q   <= st_cnt_q + 3'h1;
            end
        end

    // Read data captured in the setup phase
    always_comb
    begin
        rd_d = 32'h0000_0000;
        case (paddr)
            `OFS_CTRL:    rd_d = {6'h00, rdy_q[`OSC_PLL], en_q[`OSC_PLL], 5'h00, hse_bp_q,
                                  rdy_q[`OSC_HSE], en_q[`OSC_HSE], cal_q, trim_q,
                                  rdy_q[`OSC_HSI], en_q[`OSC_HSI]};
            `OFS_CFG:     rd_d = {7'h00, mul_q, pll_fin_div_q, pll_hsi_div_q, pll_hse_div_q,
                                  pll_src_q, 2'h0, apb2_pre_q, apb1_pre_q, ahb_pre_q,
                                  sws_q, sw_q};
            `OFS_CTRLSTS: rd_d = {24'h000000, range_q, rdy_q[`OSC_MSI], en_q[`OSC_MSI],
                                  rdy_q[`OSC_LSI], en_q[`OSC_LSI]};
            `OFS_LDCTRL:  rd_d = {15'h0000, ld_soft_q, 13'h0000, lse_bp_q,
                                  rdy_q[`OSC_LSE], en_q[`OSC_LSE]};
            `OFS_CLKINT:  rd_d = {18'h00000, ien_q, 2'h0, flag_q};
            default:      rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata_q <= rd_d;

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_ld_soft;
        ld_soft_q |-> lowpower_domain_reset;
    endproperty
    a_ld_soft: assert property (p_ld_soft) else $error("soft bit without domain reset");  // RULE1

    property p_wake;
        wake |=> (system_clock_select == 2'h0) && (multispeed_range_select == `RANGE_4MHZ);
    endproperty
    a_wake: assert property (p_wake) else $error("wake did not restore multispeed");  // RULE3

    property p_systick;
        ahb_tick |=> st_cnt_q == $past(st_cnt_q) + 3'h1;
    endproperty
    a_systick: assert property (p_systick) else $error("system tick not one in eight");  // RULE5

    property p_tim1;
        (apb1_pre_q[2] == 1'b0) |-> (timer1_tick == apb1_tick);
    endproperty
    a_tim1: assert property (p_tim1) else $error("timer clock differs at divide 1");  // RULE6

    sequence s_hse_up;
        !rdy_q[`OSC_HSE] ##1 rdy_q[`OSC_HSE];
    endsequence
    property p_hse_irq;
        (ien_q[`OSC_HSE] && !flag_q[`OSC_HSE]) ##0 s_hse_up |-> clock_irq;
    endproperty
    a_hse_irq: assert property (p_hse_irq) else $error("no interrupt on fast ready");  // RULE8

    property p_pll_lock;
        osc_enable[`OSC_PLL] |=> $stable(pll_multiply_factor) && $stable(pll_source_external);
    endproperty
    a_pll_lock: assert property (p_pll_lock) else $error("PLL setup changed while on");  // RULE15

    property p_switch;
        ($changed(system_clock_select) && system_clock_select != 2'h0) |->
            $past(rdy_q[src_idx(system_clock_select)]);
    endproperty
    a_switch: assert property (p_switch) else $error("switch to source not ready");  // RULE23

    property p_fail;
        (fail && sws_q == clk_ctrl_pkg::SRC_HSE) |=>
            (system_clock_select == 2'h0) && !osc_enable[`OSC_HSE];
    endproperty
    a_fail: assert property (p_fail) else $error("no fallback on failure");  // RULE14

    property p_rdy_off;
        !osc_enable[`OSC_LSE] |=> !rdy_q[`OSC_LSE];
    endproperty
    a_rdy_off: assert property (p_rdy_off) else $error("ready while disabled");  // RULE24

endmodule
`default_nettype wire

// ===== osc_model.sv
// Oscillator model: crystals, bypass sources and internal oscillators
// Assumes enables from the clock control unit; slow selects a long startup
`timescale 1ns/10ps
`default_nettype none
module osc_model
(
    input  wire logic       pclk,
    input  wire logic       slow,
    input  wire logic [5:0] osc_enable,
    output logic      [5:0] osc_stable
);
    logic [5:0] cnt [6] = '{default: 6'h00};
    // Stable only after a startup time while enabled, low as soon as disabled
    always @(posedge pclk)
    begin
        for (int i = 0; i < 6; i++)
        begin
            if (osc_enable[i] !== 1'b1)
                cnt[i] <= 6'h00;
            else if (cnt[i] != 6'h3f)
                cnt[i] <= cnt[i] + 6'h01;
            osc_stable[i] <= osc_enable[i] === 1'b1 && cnt[i] >= (slow ? 6'h28 : 6'h04);
        end
    end
endmodule
`default_nettype wire

// ===== clock_source_control_unit_tb.sv
// Self-checking testbench of the clock source control unit
// Assumes the design, its constants header and the oscillator model
`timescale 1ns/10ps
`default_nettype none
`include "clk_ctrl_consts.svh"
module clock_source_control_unit_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        fail = 1'b0;
    logic        vdd = 1'b0;
    logic        wake = 1'b0;
    logic        slow = 1'b0;
    logic [8:0]  fcal = 9'h000;
    logic [31:0] prdata, rd;
    logic [5:0]  stable, en, rel;
    wire  [5:0]  tk;
    logic [8:0]  cal;
    wire  [8:0]  pll;
    logic [4:0]  trim, v5;
    logic [3:0]  range, v, ex;
    logic [2:0]  p1, p2;
    logic [3:0]  ap;
    logic [1:0]  sel;
    logic        pready, pslverr, er, hbyp, lbyp, irq, ldr;
    integer      seed = 32'h1212;
    int          n_mismatch = 0;
    int          n_tests = 0;

    always #4 pclk = ~pclk;

    osc_model osc (.pclk(pclk), .slow(slow), .osc_enable(en), .osc_stable(stable));

    clock_source_control_unit dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_stable(stable),
        .fast_external_fail(fail), .vdd_power_event(vdd), .standby_wake(wake),
        .factory_calibration(fcal), .osc_enable(en), .osc_release(rel),
        .fast_external_bypass(hbyp), .slow_external_bypass(lbyp),
        .multispeed_range_select(range), .fast_internal_trim(trim),
        .fast_internal_calibration(cal), .pll_source_external(pll[8]),
        .pll_internal_input_divide(pll[7]), .pll_external_input_divide(pll[6]),
        .pll_final_divide(pll[5]), .pll_multiply_factor(pll[4:0]),
        .system_clock_select(sel), .lowpower_domain_reset(ldr), .clock_irq(irq),
        .ahb_tick(tk[0]), .apb1_tick(tk[1]), .apb2_tick(tk[2]),
        .timer1_tick(tk[3]), .timer2_tick(tk[4]), .systick_tick(tk[5])
    );

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // One APB transfer; returns at the edge that completes it
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge pclk);
    endtask

    task automatic wu(input int i, input logic b);
        int k;
        k = 0;
        while (rel[i] !== b && k < 300)
        begin
            @(negedge pclk);
            k++;
        end
    endtask

    // Cycles between two pulses of one tick output
    task automatic per(input int i, input int e);
        int c;
        for (int s = 0; s < 2; s++)
        begin
            c = 0;
            do
            begin
                @(negedge pclk);
                c++;
            end
            while (tk[i] !== 1'b1 && c < 5000);
        end
        chk(32'(c), 32'(e));
    endtask

    function automatic int adiv(input logic [3:0] p);
        return p[3] ? 2 << p[2:0] : 1;
    endfunction

    function automatic int pdiv(input logic [2:0] p);
        return p[2] ? 2 << p[1:0] : 1;
    endfunction

    initial
    begin
        repeat (60000) @(posedge pclk);
        n_mismatch++;
        conclude();
    end

    initial
    begin
        fcal = 9'($random(seed));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        wt(2);
        chk(cal, fcal);
        chk({range, trim, sel, en}, {4'h6, 5'h10, 2'h0, 6'h20});
        wu(5, 1'b1);
        apb(1'b0, `OFS_CTRLSTS, 32'h0);
        chk(rd & 32'hfc, 32'h6c);
        ex = 4'h6;
        for (int r = 0; r < 12; r++)
        begin
            v = (r < 8) ? 4'(r) : 4'($random(seed));
            if (v <= 4'h6)
                ex = v;
            apb(1'b1, `OFS_CTRLSTS, {24'h0, v, 4'h4});
            wt(1);
            chk(range, ex);
        end
        apb(1'b1, `OFS_CTRLSTS, 32'h24);
        wake <= 1'b1;
        wt(5);
        chk({range, sel}, {4'h6, 2'h0});
        apb(1'b1, `OFS_CTRLSTS, 32'h64);
        wake <= 1'b0;
        v5 = 5'($random(seed));
        apb(1'b1, `OFS_CTRL, {25'h0, v5, 2'h1});
        wt(1);
        chk({trim, rel[2]}, {v5, 1'b0});
        wu(2, 1'b1);
        apb(1'b0, `OFS_CTRL, 32'h0);
        chk(rd[1:0], 2'h3);
        apb(1'b1, `OFS_CTRL, {25'h0, v5, 2'h0});
        wt(2);
        chk(rel[2], 1'b0);
        apb(1'b0, `OFS_CTRL, 32'h0);
        chk(rd[1:0], 2'h0);
        slow <= 1'b1;
        apb(1'b1, `OFS_CLKINT, 32'h3f0800);
        apb(1'b1, `OFS_CTRL, 32'h50040);
        wt(1);
        chk({hbyp, irq, rel[3]}, 3'h4);
        wu(3, 1'b1);
        chk(irq, 1'b1);
        apb(1'b1, `OFS_CLKINT, 32'h3f1000);
        wt(1);
        chk(irq, 1'b0);
        apb(1'b1, `OFS_CFG, 32'h3);
        wt(10);
        chk(sel, 2'h0);
        apb(1'b1, `OFS_CFG, 32'h2);
        wt(5);
        chk(sel, 2'h2);
        @(posedge pclk);
        fail <= 1'b1;
        wt(5);
        chk({sel, en[3]}, 3'h0);
        m_pll();
        conclude();
    end

    task automatic m_pll();
        v5 = 5'($random(seed));
        apb(1'b1, `OFS_CFG, {7'h0, v5, 4'hc, 16'h0});
        fail <= 1'b0;
        wt(1);
        chk(pll, {4'h5, v5});
        apb(1'b1, `OFS_CTRL, 32'h1000041);
        wu(4, 1'b1);
        chk(irq, 1'b1);
        apb(1'b1, `OFS_CFG, {7'h0, ~v5, 4'h3, 16'h0});
        wt(1);
        chk(pll, {4'h5, v5});
        apb(1'b1, `OFS_LDCTRL, 32'h5);
        wt(1);
        chk(lbyp, 1'b1);
        wu(1, 1'b1);
        chk(rel[1], 1'b1);
        apb(1'b1, `OFS_LDCTRL, 32'h10005);
        wt(2);
        chk({ldr, en[1]}, 2'h2);
        apb(1'b1, `OFS_LDCTRL, 32'h0);
        wt(1);
        chk(ldr, 1'b0);
        apb(1'b1, `OFS_CTRLSTS, 32'h65);
        vdd <= 1'b1;
        wt(5);
        chk(ldr, 1'b1);
        wu(0, 1'b1);
        chk(rel[0], 1'b1);
        apb(1'b0, 12'h020, 32'h0);
        vdd <= 1'b0;
        chk({er, rd}, {1'b1, 32'h0});
        for (int j = 0; j < 4; j++)
        begin
            ap = (j == 0) ? 4'h0 : {2'b10, 2'($random(seed))};
            p1 = 3'($random(seed));
            p2 = (j == 0) ? 3'h0 : 3'($random(seed));
            apb(1'b1, `OFS_CFG, {18'h0, p2, p1, ap, 4'h0});
            per(0, adiv(ap));
            per(5, 8 * adiv(ap));
            per(1, adiv(ap) * pdiv(p1));
            per(3, adiv(ap) * pdiv(p1) / (p1[2] ? 2 : 1));
            per(2, adiv(ap) * pdiv(p2));
            per(4, adiv(ap) * pdiv(p2) / (p2[2] ? 2 : 1));
        end
    endtask
endmodule
`default_nettype wire
